// ===== rtl/tcc_cfg.svh
/*
  Register map, field positions and constants of the timer capture/compare block.
  Assumes inclusion by the design modules of the block and by the bench.
*/
//
// Behaviour
// - Running count readable as 16-bit register
// - Compare writes move into latch per policy
// - Latch, not value register, feeds comparison
// - Mode bit 8: capture copies count
// - Edge field selects none/rise/fall/both
// - Input field selects a/b/ground/supply
// - Sync bit selects synchronised or direct capture
// - Load field picks when latch loads
// - Pin action field drives channel pin
// - Channel enable gates channel interrupt request
// - Read-only bit shows selected input level
// - Mode 0 output follows direct level bit
// - Overrun set by hardware, cleared by software
// - Channel flag shows pending channel interrupt
// - Vector reports highest-priority pending source other than channel 0
// - Clear command resets counter, self-clears
// - Rollover flag requests only when enabled
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_NCH          7
// Byte offsets
`define TCC_OFS_CTRL     8'h00
`define TCC_OFS_COUNT    8'h04
`define TCC_OFS_PERIOD   8'h08
`define TCC_OFS_VECTOR   8'h0c
`define TCC_OFS_ISTAT    8'h10
`define TCC_OFS_IMASK    8'h14
`define TCC_OFS_CTL0     8'h20
`define TCC_OFS_VAL0     8'h40
// Main control bits
`define TCC_CTRL_RUN     4
`define TCC_CTRL_UPDN    3
`define TCC_CTRL_CLR     2
`define TCC_CTRL_ROLLEN  1
`define TCC_CTRL_ROLLFLG 0
// Channel control fields
`define TCC_CC_EDGE_HI   15
`define TCC_CC_EDGE_LO   14
`define TCC_CC_INS_HI    13
`define TCC_CC_INS_LO    12
`define TCC_CC_SYNC      11
`define TCC_CC_LOAD_HI   10
`define TCC_CC_LOAD_LO   9
`define TCC_CC_CAP       8
`define TCC_CC_ACT_HI    7
`define TCC_CC_ACT_LO    5
`define TCC_CC_IE        4
`define TCC_CC_LVL       3
`define TCC_CC_OUT       2
`define TCC_CC_COV       1
`define TCC_CC_FLG       0
// Vector codes
`define TCC_VEC_NONE     16'h0000
`define TCC_VEC_ROLL     16'h000e
`define TCC_RESET16      16'h0000
`endif

// ===== rtl/tcc_pkg.sv
/*
  Types of the timer capture/compare block.
  Assumes the constants header sits beside it.
*/
`default_nettype none
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_EDGE_NONE = 2'b00,
    TCC_EDGE_RISE = 2'b01,
    TCC_EDGE_FALL = 2'b10,
    TCC_EDGE_BOTH = 2'b11
  } tcc_edge_t;

  typedef enum logic [1:0] {
    TCC_LD_WRITE  = 2'b00,
    TCC_LD_ZERO   = 2'b01,
    TCC_LD_ZORP   = 2'b10,
    TCC_LD_PERIOD = 2'b11
  } tcc_load_t;

  typedef struct packed {
    tcc_edge_t  edge_sel;
    logic [1:0] input_sel;
    logic       sync;
    tcc_load_t  load_sel;
    logic       cap_mode;
    logic [2:0] action;
    logic       irq_en;
    logic       out_level;
  } tcc_chcfg_t;

  typedef struct packed {
    logic       zero;
    logic       period;
    logic       at_zero_any;
    logic [15:0] count;
  } tcc_cnt_t;
endpackage : tcc_pkg
`default_nettype wire

// ===== rtl/tcc_channel.sv
/*
  One capture/compare channel: input select, capture, shadow latch, pin action.
  Assumes config and count come from the register block on the same clock.
*/
`include "tcc_cfg.svh"
`default_nettype none
module tcc_channel
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Configuration and count
  input  wire tcc_chcfg_t  cfg,
  input  wire tcc_cnt_t    cnt,
  input  wire logic        val_we,
  input  wire logic [15:0] val_wdata,
  // Pins
  input  wire logic        in_a,
  input  wire logic        in_b,
  // Status
  output logic [15:0]      value_r,
  output logic             level,
  output logic             cap_evt,
  output logic             cap_ovr,
  output logic             match,
  output logic             pin_r
);
  logic [1:0]  a_sync_r;
  logic [1:0]  b_sync_r;
  logic        raw_lvl;
  logic        s_lvl_r;
  logic        a_lvl_r;
  logic        cap_lvl;
  logic        prev_r;
  logic        rise;
  logic        fall;
  logic [15:0] latch_r;
  logic        pend_r;
  logic        load_now;
  logic        match_d_r;

  // ------------------------------------------------------------
  // Input select and synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_sync_r <= 2'h0;
      b_sync_r <= 2'h0;
    end else begin
      a_sync_r <= {a_sync_r[0], in_a};
      b_sync_r <= {b_sync_r[0], in_b};
    end
  end

  always_comb begin
    unique case (cfg.input_sel)
      2'b00: raw_lvl = a_sync_r[1];
      2'b01: raw_lvl = b_sync_r[1];
      2'b10: raw_lvl = 1'b0;
      2'b11: raw_lvl = 1'b1;
    endcase
  end

  // Synchronised mode adds a stage aligned to the timer clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_lvl_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      s_lvl_r <= raw_lvl;
      prev_r  <= cap_lvl;
    end
  end
  assign a_lvl_r = raw_lvl;
  assign cap_lvl = cfg.sync ? s_lvl_r : a_lvl_r;
  assign level   = raw_lvl;
  assign rise    = cap_lvl & ~prev_r;
  assign fall    = ~cap_lvl & prev_r;

  // ------------------------------------------------------------
  // Capture
  // ------------------------------------------------------------
  always_comb begin
    unique case (cfg.edge_sel)
      TCC_EDGE_NONE: cap_evt = 1'b0;
      TCC_EDGE_RISE: cap_evt = cfg.cap_mode & rise;
      TCC_EDGE_FALL: cap_evt = cfg.cap_mode & fall;
      TCC_EDGE_BOTH: cap_evt = cfg.cap_mode & (rise | fall);
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_r <= `TCC_RESET16;
    end else if (cap_evt) begin
      value_r <= cnt.count;
    end else if (val_we) begin
      value_r <= val_wdata;
    end
  end

  // ------------------------------------------------------------
  // Shadow latch and compare
  // ------------------------------------------------------------
  always_comb begin
    unique case (cfg.load_sel)
      TCC_LD_WRITE:  load_now = val_we;
      TCC_LD_ZERO:   load_now = pend_r & cnt.zero;
      TCC_LD_ZORP:   load_now = pend_r & cnt.at_zero_any;
      TCC_LD_PERIOD: load_now = pend_r & cnt.period;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_r <= `TCC_RESET16;
      pend_r  <= 1'b0;
    end else if (!cfg.cap_mode) begin
      if (load_now) begin
        latch_r <= (cfg.load_sel == TCC_LD_WRITE) ? val_wdata : value_r;
        pend_r  <= 1'b0;
      end else if (val_we) begin
        pend_r  <= 1'b1;
      end
    end
  end

  // Compare against the latch only
  assign match   = !cfg.cap_mode && (cnt.count == latch_r) && !match_d_r;
  // Second capture before the flag is serviced is an overrun
  assign cap_ovr = cap_evt;

  always_ff @(posedge hclk or negedge hresetn) begin
    // Count and latch both leave reset at zero: no match out of reset
    if (!hresetn) begin
      match_d_r <= 1'b1;
    end else begin
      match_d_r <= !cfg.cap_mode && (cnt.count == latch_r);
    end
  end

  // ------------------------------------------------------------
  // Pin action
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_r <= 1'b0;
    end else if (cfg.action == 3'h0) begin
      pin_r <= cfg.out_level;
    end else begin
      unique case (cfg.action)
        3'h1: if (match) pin_r <= 1'b1;
        3'h2: if (match) pin_r <= ~pin_r; else if (cnt.period) pin_r <= 1'b0;
        3'h3: if (match) pin_r <= 1'b1; else if (cnt.period) pin_r <= 1'b0;
        3'h4: if (match) pin_r <= ~pin_r;
        3'h5: if (match) pin_r <= 1'b0;
        3'h6: if (match) pin_r <= ~pin_r; else if (cnt.period) pin_r <= 1'b1;
        3'h7: if (match) pin_r <= 1'b0; else if (cnt.period) pin_r <= 1'b1;
        default: pin_r <= pin_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  direct_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(cfg) && cfg.action == 3'h0 |=> pin_r == $past(cfg.out_level))
    else $error("pin does not follow direct level");
  capture_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_evt |=> value_r == $past(cnt.count))
    else $error("capture did not copy count");
  edge_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg.edge_sel == TCC_EDGE_NONE |-> !cap_evt)
    else $error("capture while disabled");
  in_gnd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg.input_sel == 2'b10 |-> !level)
    else $error("ground input not low");
  ld_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg.cap_mode && cfg.load_sel == TCC_LD_WRITE && val_we
      |=> latch_r == $past(val_wdata))
    else $error("latch not loaded on write");
endmodule : tcc_channel
`default_nettype wire

// ===== rtl/tcc_top.sv
/*
  Timer capture/compare block with AHB-Lite register slave.
  Assumes a single-master AHB-Lite bus, word transfers, hclk at 125 MHz.
*/
`include "tcc_cfg.svh"
`default_nettype none
module tcc_top
  import tcc_pkg::*;
(
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Capture inputs and channel pins
  input  wire logic [6:0]  capture_input_a,
  input  wire logic [6:0]  capture_input_b,
  output logic [6:0]       cc_pin,
  // Interrupt
  output logic             irq
);
  localparam int NCH = `TCC_NCH;

  logic            a_wr_r;
  logic            a_rd_r;
  logic [7:0]      a_addr_r;
  logic [15:0]     ctl_r [NCH];
  tcc_chcfg_t      cfg [NCH];
  logic [15:0]     val [NCH];
  logic [NCH-1:0]  lvl;
  logic [NCH-1:0]  cap_evt;
  logic [NCH-1:0]  cap_ovr;
  logic [NCH-1:0]  match;
  logic [NCH-1:0]  val_we;
  logic [NCH-1:0]  flg_r;
  logic [NCH-1:0]  cov_r;
  logic [15:0]     count_r;
  logic [15:0]     period_r;
  logic            run_r;
  logic            updn_r;
  logic            down_r;
  logic            roll_en_r;
  logic            roll_flg_r;
  logic            roll_evt;
  logic [1:0]      istat_r;
  logic [1:0]      imask_r;
  logic [15:0]     vec;
  logic [NCH-1:0]  vec_clr;
  logic            vec_roll_clr;
  logic            vec_rd;
  tcc_cnt_t        cnt;
  logic [31:0]     rdata;

  // ------------------------------------------------------------
  // Bus address phase capture
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr_r   <= 1'b0;
      a_rd_r   <= 1'b0;
      a_addr_r <= 8'h00;
    end else if (hready) begin
      a_wr_r   <= hsel & htrans[1] & hwrite;
      a_rd_r   <= hsel & htrans[1] & ~hwrite;
      a_addr_r <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  wire clr_cmd = a_wr_r && a_addr_r == `TCC_OFS_CTRL && hwdata[`TCC_CTRL_CLR];
  assign cnt.count       = count_r;
  assign cnt.zero        = run_r && count_r == 16'h0000;
  assign cnt.period      = run_r && count_r == period_r;
  assign cnt.at_zero_any = cnt.zero | (updn_r & cnt.period);
  assign roll_evt        = run_r && (updn_r ? (down_r && count_r == 16'h0001)
                                             : (count_r == period_r));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= `TCC_RESET16;
      down_r  <= 1'b0;
    end else if (clr_cmd) begin
      count_r <= `TCC_RESET16;
      down_r  <= 1'b0;
    end else if (a_wr_r && a_addr_r == `TCC_OFS_COUNT) begin
      count_r <= hwdata[15:0];
    end else if (run_r) begin
      if (updn_r) begin
        if (!down_r && count_r == period_r) begin
          down_r  <= 1'b1;
          count_r <= count_r - 16'h0001;
        end else if (down_r && count_r == 16'h0001) begin
          down_r  <= 1'b0;
          count_r <= 16'h0000;
        end else begin
          count_r <= down_r ? count_r - 16'h0001 : count_r + 16'h0001;
        end
      end else begin
        count_r <= (count_r == period_r) ? 16'h0000 : count_r + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Main control and period
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r     <= 1'b0;
      updn_r    <= 1'b0;
      roll_en_r <= 1'b0;
      period_r  <= 16'hffff;
    end else if (a_wr_r) begin
      if (a_addr_r == `TCC_OFS_CTRL) begin
        run_r     <= hwdata[`TCC_CTRL_RUN];
        updn_r    <= hwdata[`TCC_CTRL_UPDN];
        roll_en_r <= hwdata[`TCC_CTRL_ROLLEN];
      end
      if (a_addr_r == `TCC_OFS_PERIOD) begin
        period_r <= hwdata[15:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      roll_flg_r <= 1'b0;
    end else if (roll_evt) begin
      roll_flg_r <= 1'b1;
    end else if (vec_roll_clr) begin
      roll_flg_r <= 1'b0;
    end else if (a_wr_r && a_addr_r == `TCC_OFS_CTRL) begin
      roll_flg_r <= hwdata[`TCC_CTRL_ROLLFLG];
    end
  end

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    wire [7:0] ctl_ofs = 8'(`TCC_OFS_CTL0 + 4 * i);
    wire [7:0] val_ofs = 8'(`TCC_OFS_VAL0 + 4 * i);
    wire       ctl_we  = a_wr_r && a_addr_r == ctl_ofs;
    assign val_we[i] = a_wr_r && a_addr_r == val_ofs;
    assign cfg[i] = '{edge_sel:  tcc_edge_t'(ctl_r[i][15:14]),
                      input_sel: ctl_r[i][13:12],
                      sync:      ctl_r[i][`TCC_CC_SYNC],
                      load_sel:  tcc_load_t'(ctl_r[i][10:9]),
                      cap_mode:  ctl_r[i][`TCC_CC_CAP],
                      action:    ctl_r[i][7:5],
                      irq_en:    ctl_r[i][`TCC_CC_IE],
                      out_level: ctl_r[i][`TCC_CC_OUT]};

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctl_r[i] <= `TCC_RESET16;
      end else if (ctl_we) begin
        ctl_r[i] <= hwdata[15:0];
      end
    end

    // Set wins over every clear
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flg_r[i] <= 1'b0;
        cov_r[i] <= 1'b0;
      end else begin
        if (cap_evt[i] || match[i]) begin
          flg_r[i] <= 1'b1;
        end else if (vec_clr[i]) begin
          flg_r[i] <= 1'b0;
        end else if (ctl_we) begin
          flg_r[i] <= hwdata[`TCC_CC_FLG];
        end
        if (cap_ovr[i] && flg_r[i]) begin
          cov_r[i] <= 1'b1;
        end else if (ctl_we && !hwdata[`TCC_CC_COV]) begin
          cov_r[i] <= 1'b0;
        end
      end
    end

    tcc_channel u_ch (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .cfg       (cfg[i]),
      .cnt       (cnt),
      .val_we    (val_we[i]),
      .val_wdata (hwdata[15:0]),
      .in_a      (capture_input_a[i]),
      .in_b      (capture_input_b[i]),
      .value_r   (val[i]),
      .level     (lvl[i]),
      .cap_evt   (cap_evt[i]),
      .cap_ovr   (cap_ovr[i]),
      .match     (match[i]),
      .pin_r     (cc_pin[i])
    );
  end

  // ------------------------------------------------------------
  // Interrupt vector
  // ------------------------------------------------------------
  assign vec_rd = a_rd_r && a_addr_r == `TCC_OFS_VECTOR;

  always_comb begin
    vec          = `TCC_VEC_NONE;
    vec_clr      = '0;
    vec_roll_clr = 1'b0;
    if (roll_flg_r && roll_en_r) begin
      vec          = `TCC_VEC_ROLL;
      vec_roll_clr = vec_rd;
    end
    for (int k = NCH - 1; k >= 1; k--) begin
      if (flg_r[k] && cfg[k].irq_en) begin
        vec          = 16'(2 * k);
        vec_clr      = '0;
        vec_clr[k]   = vec_rd;
        vec_roll_clr = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Sticky status, mask, interrupt line
  // ------------------------------------------------------------
  wire ch0_req = flg_r[0] & cfg[0].irq_en;
  wire vec_req = vec != `TCC_VEC_NONE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_r <= 2'h0;
      imask_r <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == 0) ? ch0_req : vec_req) begin
          istat_r[b] <= 1'b1;
        end else if (a_wr_r && a_addr_r == `TCC_OFS_ISTAT && hwdata[b]) begin
          istat_r[b] <= 1'b0;
        end
      end
      if (a_wr_r && a_addr_r == `TCC_OFS_IMASK) begin
        imask_r <= hwdata[1:0];
      end
    end
  end
  assign irq = |(istat_r & imask_r);

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (a_addr_r)
      `TCC_OFS_CTRL:   rdata = {27'h0, run_r, updn_r, 1'b0, roll_en_r, roll_flg_r};
      `TCC_OFS_COUNT:  rdata = {16'h0, count_r};
      `TCC_OFS_PERIOD: rdata = {16'h0, period_r};
      `TCC_OFS_VECTOR: rdata = {16'h0, vec};
      `TCC_OFS_ISTAT:  rdata = {30'h0, istat_r};
      `TCC_OFS_IMASK:  rdata = {30'h0, imask_r};
      default: begin
        for (int c = 0; c < NCH; c++) begin
          if (a_addr_r == 8'(`TCC_OFS_CTL0 + 4 * c)) begin
            rdata = {16'h0, ctl_r[c][15:4], lvl[c], ctl_r[c][2], cov_r[c], flg_r[c]};
          end
          if (a_addr_r == 8'(`TCC_OFS_VAL0 + 4 * c)) begin
            rdata = {16'h0, val[c]};
          end
        end
      end
    endcase
  end
  assign hrdata = a_rd_r ? rdata : 32'h0000_0000;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  clear_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_cmd |=> count_r == 16'h0000 && !down_r)
    else $error("clear did not reset counter");
  roll_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !roll_en_r && flg_r[NCH-1:1] == '0 |-> vec == 16'h0000)
    else $error("rollover reported while disabled");
  vec_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
    flg_r[1] && cfg[1].irq_en |-> vec == 16'h0002)
    else $error("channel 1 not highest");
  vec_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_rd && vec == 16'h0002 && !cap_evt[1] && !match[1] |=> !flg_r[1])
    else $error("vector read did not clear flag");
  irq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
    imask_r == 2'h0 |-> !irq)
    else $error("masked interrupt raised");
  flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_evt[2] |=> flg_r[2])
    else $error("capture did not set flag");
  ovr_stick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cov_r[3] && !(a_wr_r && a_addr_r == 8'h2c) |=> cov_r[3])
    else $error("overrun dropped without software");
endmodule : tcc_top
`default_nettype wire

// ===== tb/testbench.sv
/*
  Self-checking bench of the timer capture/compare block: reset values, count,
  direct pins, input select, capture, vector, interrupt, compare, rollover.
  Assumes the block alone on one AHB-Lite bus, hclk at 125 MHz.
*/
`include "tcc_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Signals
  // --------
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [6:0]  cap_a = 7'h00;
  logic [6:0]  cap_b = 7'h00;
  logic [6:0]  cc_pin;
  logic [6:0]  pat;
  logic [15:0] cv;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          seed = 32'h04c5;
  logic [31:0] exp_q[$];
  logic [7:0]  rst_ofs [7] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h40};
  logic [31:0] cfg [6] = '{32'h0, 32'h4110, 32'h8110, 32'hc110, 32'h4100, 32'h0110};

  always #4 hclk = ~hclk;

  tcc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_input_a(cap_a),
    .capture_input_b(cap_b), .cc_pin(cc_pin), .irq(irq));

  // --------
  // Tasks
  // --------
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Single word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  function automatic logic [7:0] at(input logic [7:0] base, input int i);
    return base + 8'(4 * i);
  endfunction : at

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end

  // --------
  // Sequence
  // --------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rst_ofs[i]) rdchk(rst_ofs[i], 32'h0);
    bus(1'b1, 8'h80, 32'hffff_ffff);
    rdchk(8'h80, 32'h0);
    cv = 16'($random(seed));
    bus(1'b1, `TCC_OFS_COUNT, {16'h0, cv});
    rdchk(`TCC_OFS_COUNT, {16'h0, cv});
    bus(1'b1, `TCC_OFS_CTRL, 32'h4);
    rdchk(`TCC_OFS_COUNT, 32'h0);
    rdchk(`TCC_OFS_CTRL, 32'h0);
    // Direct pin levels
    pat = 7'($random(seed));
    for (int i = 0; i < 7; i++) bus(1'b1, at(`TCC_OFS_CTL0, i), {29'h0, pat[i], 2'b00});
    repeat (3) @(posedge hclk);
    check({25'h0, cc_pin}, {25'h0, pat});
    // Input select and level bit
    cap_a <= 7'h01;
    cap_b <= 7'($random(seed));
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `TCC_OFS_CTL0, 32'(s) << 12);
      repeat (4) @(posedge hclk);
      rdchk(`TCC_OFS_CTL0, (32'(s) << 12) | ((s == 0 || s == 3 || (s == 1 && cap_b[0]))
        ? 32'h8 : 32'h0));
    end
    cap_a <= 7'h00;
    // Capture on channels 1 to 5, one edge mode each
    cv = 16'($random(seed));
    bus(1'b1, `TCC_OFS_CTL0, 32'h0);
    bus(1'b1, `TCC_OFS_COUNT, {16'h0, cv});
    for (int i = 1; i < 6; i++) bus(1'b1, at(`TCC_OFS_CTL0, i), cfg[i]);
    cap_a <= 7'h3e;
    repeat (8) @(posedge hclk);
    cap_a <= 7'h00;
    repeat (8) @(posedge hclk);
    rdchk(`TCC_OFS_ISTAT, 32'h2);
    bus(1'b1, `TCC_OFS_IMASK, 32'h0);
    @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, `TCC_OFS_IMASK, 32'h2);
    @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    exp_q = '{32'h2, 32'h4, 32'h6, 32'h0};
    while (exp_q.size() > 0) rdchk(`TCC_OFS_VECTOR, exp_q.pop_front());
    for (int i = 1; i < 6; i++) begin
      rdchk(at(`TCC_OFS_VAL0, i), i == 5 ? 32'h0 : {16'h0, cv});
      rdchk(at(`TCC_OFS_CTL0, i), cfg[i] | (i == 3 ? 32'h2 : 32'h0)
        | (i == 4 ? 32'h1 : 32'h0));
    end
    bus(1'b1, `TCC_OFS_ISTAT, 32'h3);
    rdchk(`TCC_OFS_ISTAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, at(`TCC_OFS_CTL0, 3), cfg[3]);
    rdchk(at(`TCC_OFS_CTL0, 3), cfg[3]);
    for (int i = 1; i < 6; i++) bus(1'b1, at(`TCC_OFS_CTL0, i), 32'h0);
    // Compare through the latch, then a deferred latch load
    bus(1'b1, at(`TCC_OFS_CTL0, 6), 32'h90);
    bus(1'b1, at(`TCC_OFS_VAL0, 6), 32'h10);
    bus(1'b1, `TCC_OFS_COUNT, 32'h0);
    bus(1'b1, `TCC_OFS_CTRL, 32'h10);
    repeat (40) @(posedge hclk);
    rdchk(at(`TCC_OFS_CTL0, 6), 32'h91);
    check({31'h0, cc_pin[6]}, {31'h0, ~pat[6]});
    rdchk(`TCC_OFS_VECTOR, 32'hc);
    bus(1'b1, `TCC_OFS_CTRL, 32'h0);
    bus(1'b1, at(`TCC_OFS_CTL0, 6), 32'h210);
    bus(1'b1, at(`TCC_OFS_VAL0, 6), 32'h110);
    bus(1'b1, `TCC_OFS_COUNT, 32'h100);
    bus(1'b1, `TCC_OFS_CTRL, 32'h10);
    repeat (40) @(posedge hclk);
    rdchk(at(`TCC_OFS_CTL0, 6), 32'h210);
    // Rollover
    bus(1'b1, `TCC_OFS_CTRL, 32'h0);
    bus(1'b1, at(`TCC_OFS_CTL0, 6), 32'h0);
    bus(1'b1, `TCC_OFS_PERIOD, 32'h20);
    bus(1'b1, `TCC_OFS_COUNT, 32'h0);
    bus(1'b1, `TCC_OFS_CTRL, 32'h12);
    repeat (50) @(posedge hclk);
    rdchk(`TCC_OFS_CTRL, 32'h13);
    bus(1'b1, `TCC_OFS_CTRL, 32'h3);
    rdchk(`TCC_OFS_VECTOR, 32'he);
    rdchk(`TCC_OFS_VECTOR, 32'h0);
    rdchk(`TCC_OFS_CTRL, 32'h2);
    summarize();
  end
endmodule : testbench
`default_nettype wire
